// [sxe_params.svh]
/*
  constants for the serial nonvolatile memory slave: opcodes, status
  layout, pin positions, protection bases and write timing.
  assumes: included by bare name from the package and the design file.
*/
`ifndef SXE_PARAMS_SVH
`define SXE_PARAMS_SVH

`define SXE_OP_SET_LATCH  8'h06
`define SXE_OP_CLR_LATCH  8'h04
`define SXE_OP_STAT_RD    8'h05
`define SXE_OP_STAT_WR    8'h01
`define SXE_OP_ARR_RD     8'h03
`define SXE_OP_ARR_WR     8'h02

`define SXE_SR_GUARD      7
`define SXE_SR_BLK_HI     3
`define SXE_SR_BLK_LO     2
`define SXE_SR_LATCH      1
`define SXE_SR_BUSY       0
`define SXE_SR_RST        8'h00
`define SXE_SR_WMASK      8'h8c
`define SXE_SR_BUSY_VAL   8'hff

`define SXE_PIN_CS        4
`define SXE_PIN_SCK       3
`define SXE_PIN_SI        2
`define SXE_PIN_HOLD      1
`define SXE_PIN_WP        0
`define SXE_PIN_IDLE      5'h13

`define SXE_ADDR_W        13
`define SXE_MEM_WORDS     8192
`define SXE_PAGE_BYTES    32
`define SXE_PROT_QUARTER  13'h1800
`define SXE_PROT_HALF     13'h1000
`define SXE_FIFO_DEPTH    8

`define SXE_CLK_PERIOD_NS 20
`define SXE_WR_TIME_NS    5000000
`define SXE_WR_CYCLES     (`SXE_WR_TIME_NS / `SXE_CLK_PERIOD_NS)

`endif

// [sxe_pkg.sv]
/*
  types for the serial nonvolatile memory slave.
  assumes: sxe_params.svh is on the include path.
*/
`default_nettype none
`include "sxe_params.svh"

package sxe_pkg;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
    logic wp_n;
  } sxe_pins_t;

  typedef enum logic [3:0] {
    S_IDLE, S_CMD, S_ADDR, S_WDAT, S_RD, S_RS, S_WSR, S_WEN, S_WDI, S_IGN
  } sxe_state_t;

endpackage

`default_nettype wire

// [sxe_eeprom.sv]
/*
  serial slave of an 8k x 8 nonvolatile memory: pin synchronisers,
  instruction decode, write latch, status register, page buffer,
  self-timed write, and a read prefetch fifo.
  assumes: all pins come from outside clk_sys and are slow against it
  (serial clock period many times the system period).
*/
`default_nettype none
`timescale 1ns/1ps
`include "sxe_params.svh"

module sxe_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  input  wire logic         flush,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  buf_q [0:D-1];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_q != (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data  = buf_q[rp_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk_sys) begin
    if (!rstn || flush) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      buf_q[wp_q] <= in_data;
    end
  end
endmodule

// Summary of operation
// - serial output bit changes only on serial clock falling edges.
// - opcode, address and data bits captured on serial clock rising edges.
// - chip select high deselects, output released, standby unless writing.
// - nothing accepted after reset until chip select falls.
// - guard pin low with guard bit set refuses status writes.
// - guard pin falling during status write abandons it before commit.
// - guard pin ignored while guard bit is zero.
// - pause input freezes sequence; host moves it only with clock low.
// - eight-bit instruction register; everything shifted msb first.
// - first bit on first rising edge after select; clock may stop.
// - latch set and cleared by commands; no write without latch.
// - latch cleared at reset and after every write cycle.
// - status readable at any time, also while busy.
// - status layout guard, unused, block pair, latch, busy.
// - latch and busy bits are driven only internally.
// - busy reads one during a write, other bits then read one.
// - block pair selects none, upper quarter, upper half, or all.
// - protected addresses readable, writes to them refused.
// - opcodes 06 set latch, 04 clear latch, 05 read status.
// - opcodes 01 write status, 03 array read, 02 array write.
// - array write takes one to 32 bytes from given address.
// - sixteen address bits follow; only the low 13 are used.
// - array read increments address per byte, wraps to zero.
// - write starts only if select rises right after a byte.
// - page writes wrap within the 32-byte page.
module sxe_eeprom #(
  parameter int WR_CYCLES = `SXE_WR_CYCLES
) (
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  input  wire sxe_pkg::sxe_pins_t pins,
  output logic                   so,
  output logic                   so_oe,
  output logic                   standby
);
  import sxe_pkg::*;

  logic [4:0]  pin_raw;
  logic [4:0]  s1_q;
  logic [4:0]  s2_q;
  logic [4:0]  s3_q;
  logic [4:0]  flt_q;
  logic [4:0]  flt_d;
  logic        cs_fall;
  logic        cs_rise;
  logic        sck_rise;
  logic        sck_fall;
  logic        sel_q;
  logic [2:0]  boot_q;
  logic        arm_q;
  logic        act;
  logic        si_bit;
  sxe_state_t  st_q;
  logic [4:0]  bit_cnt_q;
  logic [15:0] sh_q;
  logic [7:0]  op_in;
  logic [7:0]  byte_in;
  logic        wr_op_q;
  logic [12:0] addr_q;
  logic [4:0]  pg_off_q;
  logic [7:0]  pg_buf_q [0:`SXE_PAGE_BYTES-1];
  logic [31:0] pg_mask_q;
  logic        pg_we;
  logic [7:0]  sr_new_q;
  logic [7:0]  nv_q;
  logic        wel_q;
  logic        busy_q;
  logic        kind_sr_q;
  logic [31:0] tmr_q;
  logic [5:0]  drain_q;
  logic        go_arr;
  logic        go_sr;
  logic        wr_done;
  logic        guard_on;
  logic [7:0]  stat;
  logic [7:0]  mem [0:`SXE_MEM_WORDS-1];
  logic [12:0] drain_addr;
  logic        mem_we;
  logic [12:0] rd_addr_q;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [7:0]  fifo_out_data;
  logic        pop;
  logic [2:0]  out_cnt_q;
  logic [7:0]  out_sh_q;
  logic [7:0]  out_byte;

  function automatic logic is_prot(input logic [1:0]  bp,
                                   input logic [12:0] a);
    unique case (bp)
      2'b00: is_prot = 1'b0;
      2'b01: is_prot = (a >= `SXE_PROT_QUARTER);
      2'b10: is_prot = (a >= `SXE_PROT_HALF);
      2'b11: is_prot = 1'b1;
    endcase
  endfunction

  // pins: three stages, a level counts once stages two and three agree
  assign pin_raw = {pins.cs_n, pins.sck, pins.si, pins.hold_n, pins.wp_n};
  assign flt_d   = (s2_q & s3_q) | (flt_q & (s2_q ^ s3_q));

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s1_q  <= `SXE_PIN_IDLE;
      s2_q  <= `SXE_PIN_IDLE;
      s3_q  <= `SXE_PIN_IDLE;
      flt_q <= `SXE_PIN_IDLE;
    end else begin
      s1_q  <= pin_raw;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      flt_q <= flt_d;
    end
  end

  assign cs_fall  = flt_q[`SXE_PIN_CS] & ~flt_d[`SXE_PIN_CS];
  assign cs_rise  = ~flt_q[`SXE_PIN_CS] & flt_d[`SXE_PIN_CS];
  assign sck_rise = ~flt_q[`SXE_PIN_SCK] & flt_d[`SXE_PIN_SCK];
  assign sck_fall = flt_q[`SXE_PIN_SCK] & ~flt_d[`SXE_PIN_SCK];
  // pause just masks clock edges, so the sequence resumes untouched
  assign act      = sel_q & flt_q[`SXE_PIN_HOLD];
  assign si_bit   = flt_q[`SXE_PIN_SI];
  assign op_in    = {sh_q[6:0], si_bit};
  assign byte_in  = op_in;

  // filter starts at idle, so a cs held low through reset looks like a
  // fall; arm selection only once the real pin has been seen high
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      boot_q <= 3'h0;
      arm_q  <= 1'b0;
    end else begin
      if (!boot_q[2]) begin
        boot_q <= boot_q + 3'h1;
      end
      if (boot_q[2] && flt_q[`SXE_PIN_CS]) begin
        arm_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sel_q <= 1'b0;
    end else if (cs_rise) begin
      sel_q <= 1'b0;
    end else if (cs_fall && arm_q) begin
      sel_q <= 1'b1;
    end
  end

  assign guard_on = nv_q[`SXE_SR_GUARD] & ~flt_q[`SXE_PIN_WP];
  assign go_arr   = cs_rise & (st_q == S_WDAT) & (bit_cnt_q == 5'h00) &
                    (pg_mask_q != 32'h0) & wel_q;
  assign go_sr    = cs_rise & (st_q == S_WSR) & (bit_cnt_q == 5'h08) &
                    wel_q & ~guard_on;
  assign pg_we    = sck_rise & act & (st_q == S_WDAT) &
                    (bit_cnt_q == 5'h07);

  // serial sequencer
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      st_q      <= S_IDLE;
      bit_cnt_q <= 5'h00;
      sh_q      <= 16'h0000;
      addr_q    <= 13'h0000;
      wr_op_q   <= 1'b0;
      sr_new_q  <= 8'h00;
    end else if (cs_rise) begin
      st_q <= S_IDLE;
    end else if (cs_fall) begin
      st_q      <= S_CMD;
      bit_cnt_q <= 5'h00;
    end else if (act && st_q == S_WSR && guard_on) begin
      st_q <= S_IGN;
    end else if (sck_rise && act) begin
      sh_q <= {sh_q[14:0], si_bit};
      unique case (st_q)
        S_CMD: begin
          bit_cnt_q <= bit_cnt_q + 5'h01;
          if (bit_cnt_q == 5'h07) begin
            bit_cnt_q <= 5'h00;
            if (busy_q && op_in != `SXE_OP_STAT_RD) begin
              st_q <= S_IGN;
            end else begin
              unique case (op_in)
                `SXE_OP_SET_LATCH: st_q <= S_WEN;
                `SXE_OP_CLR_LATCH: st_q <= S_WDI;
                `SXE_OP_STAT_RD:   st_q <= S_RS;
                `SXE_OP_STAT_WR:   st_q <= S_WSR;
                `SXE_OP_ARR_RD: begin
                  st_q    <= S_ADDR;
                  wr_op_q <= 1'b0;
                end
                `SXE_OP_ARR_WR: begin
                  st_q    <= S_ADDR;
                  wr_op_q <= 1'b1;
                end
                default: st_q <= S_IGN;
              endcase
            end
          end
        end
        S_ADDR: begin
          bit_cnt_q <= bit_cnt_q + 5'h01;
          if (bit_cnt_q == 5'h0f) begin
            bit_cnt_q <= 5'h00;
            addr_q    <= {sh_q[11:0], si_bit};
            st_q      <= wr_op_q ? S_WDAT : S_RD;
          end
        end
        S_WDAT: begin
          bit_cnt_q <= (bit_cnt_q == 5'h07) ? 5'h00 : bit_cnt_q + 5'h01;
        end
        S_WSR: begin
          if (bit_cnt_q == 5'h08) begin
            st_q <= S_IGN;
          end else begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
            if (bit_cnt_q == 5'h07) begin
              sr_new_q <= byte_in;
            end
          end
        end
        // extra clocks after a latch command void it
        S_WEN, S_WDI: st_q <= S_IGN;
        S_RD, S_RS, S_IGN, S_IDLE: st_q <= st_q;
      endcase
    end
  end

  // page buffer: offset wraps inside the page, later bytes overwrite
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pg_off_q  <= 5'h00;
      pg_mask_q <= 32'h0;
    end else if (cs_fall && !busy_q) begin
      // a status poll during the drain must not wipe the pending bytes
      pg_mask_q <= 32'h0;
    end else if (sck_rise && act && st_q == S_ADDR &&
                 bit_cnt_q == 5'h0f) begin
      pg_off_q <= {sh_q[3:0], si_bit};
    end else if (pg_we) begin
      pg_mask_q[pg_off_q] <= 1'b1;
      pg_off_q            <= pg_off_q + 5'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (pg_we) begin
      pg_buf_q[pg_off_q] <= byte_in;
    end
  end

  // self-timed write; memory drained from the page in the first cycles
  assign wr_done    = busy_q && (tmr_q == 32'(WR_CYCLES - 1));
  assign drain_addr = {addr_q[12:5], drain_q[4:0]};
  assign mem_we     = busy_q & ~kind_sr_q & ~drain_q[5] &
                      pg_mask_q[drain_q[4:0]] &
                      ~is_prot(nv_q[3:2], drain_addr);

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      busy_q    <= 1'b0;
      kind_sr_q <= 1'b0;
      tmr_q     <= 32'h0;
      drain_q   <= 6'h00;
      nv_q      <= `SXE_SR_RST;
    end else if (go_arr || go_sr) begin
      busy_q    <= 1'b1;
      kind_sr_q <= go_sr;
      tmr_q     <= 32'h0;
      drain_q   <= 6'h00;
    end else if (busy_q) begin
      tmr_q <= tmr_q + 32'h1;
      if (!drain_q[5]) begin
        drain_q <= drain_q + 6'h01;
      end
      if (wr_done) begin
        busy_q <= 1'b0;
        // the guard pin no longer matters once the cycle is under way
        if (kind_sr_q) begin
          nv_q <= sr_new_q & `SXE_SR_WMASK;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (mem_we) begin
      mem[drain_addr] <= pg_buf_q[drain_q[4:0]];
    end
  end

  // write latch, only internal events reach it
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wel_q <= 1'b0;
    end else if (wr_done) begin
      wel_q <= 1'b0;
    end else if (cs_rise && st_q == S_WEN) begin
      wel_q <= 1'b1;
    end else if (cs_rise && st_q == S_WDI) begin
      wel_q <= 1'b0;
    end
  end

  assign stat = busy_q ? `SXE_SR_BUSY_VAL :
                {nv_q[7], 3'b000, nv_q[3:2], wel_q, 1'b0};

  // prefetch keeps the fifo topped up; a full fifo stalls it
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rd_addr_q <= 13'h0000;
    end else if (sck_rise && act && st_q == S_ADDR &&
                 bit_cnt_q == 5'h0f) begin
      rd_addr_q <= {sh_q[11:0], si_bit};
    end else if (st_q == S_RD && fifo_in_ready) begin
      rd_addr_q <= rd_addr_q + 13'h0001;
    end
  end

  sxe_fifo #(
    .W (8),
    .D (`SXE_FIFO_DEPTH)
  ) u_rd_fifo (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .flush     (cs_rise | cs_fall),
    .in_valid  (st_q == S_RD),
    .in_ready  (fifo_in_ready),
    .in_data   (mem[rd_addr_q]),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data)
  );

  assign pop      = sck_fall & act & (st_q == S_RD) &
                    (out_cnt_q == 3'h0) & fifo_out_valid;
  assign out_byte = (st_q == S_RD) ? fifo_out_data : stat;

  // output shifter; status reloaded live every byte for busy polling
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      so        <= 1'b0;
      out_cnt_q <= 3'h0;
      out_sh_q  <= 8'h00;
    end else if (cs_fall) begin
      out_cnt_q <= 3'h0;
    end else if (sck_fall && act && (st_q == S_RD || st_q == S_RS)) begin
      if (out_cnt_q == 3'h0) begin
        so        <= out_byte[7];
        out_sh_q  <= {out_byte[6:0], 1'b0};
        out_cnt_q <= 3'h7;
      end else begin
        so        <= out_sh_q[7];
        out_sh_q  <= {out_sh_q[6:0], 1'b0};
        out_cnt_q <= out_cnt_q - 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      so_oe   <= 1'b0;
      standby <= 1'b1;
    end else begin
      so_oe   <= act & ~cs_rise & (st_q == S_RD || st_q == S_RS);
      standby <= flt_q[`SXE_PIN_CS] & ~busy_q;
    end
  end

endmodule

`default_nettype wire

// [sxe_eeprom_sva.sv]
/* checker on the ports of sxe_eeprom.
   assumes: pins slow against clk_sys, bound below. */
`timescale 1ns/1ps
`default_nettype none
module sxe_eeprom_sva (
  input wire logic               clk_sys,
  input wire logic               rstn,
  input wire sxe_pkg::sxe_pins_t pins,
  input wire logic               so,
  input wire logic               so_oe,
  input wire logic               standby
);
  import sxe_pkg::*;
  logic [3:0] fall_q;
  logic [3:0] sel_q;
  // ages saturate so long frames never wrap them
  always_ff @(posedge clk_sys) begin
    if (!rstn || $fell(pins.sck)) fall_q <= 4'h0;
    else if (fall_q != 4'hf) fall_q <= fall_q + 4'h1;
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn || pins.cs_n || !pins.hold_n) sel_q <= 4'h0;
    else if (sel_q != 4'hf) sel_q <= sel_q + 4'h1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  a_reset_idle: assert property (!rstn |=> standby && !so_oe)
    else $error("outputs not idle after reset");
  a_desel_quiet: assert property (disable iff (!rstn)
    pins.cs_n [*8] |-> !so_oe) else $error("so driven while deselected");
  a_select_active: assert property (disable iff (!rstn)
    !pins.cs_n [*8] |-> !standby) else $error("standby while selected");
  // sel_q guard: frame edges may legally move so away from clock falls
  a_so_on_fall: assert property (disable iff (!rstn)
    $changed(so) && so_oe && $past(so_oe) && sel_q > 4'h8
    |-> fall_q inside {[1:6]}) else $error("so moved off a clock fall");
  a_hold_no_drive: assert property (disable iff (!rstn)
    !pins.hold_n [*8] |-> !so_oe) else $error("so driven while paused");
  a_hold_frozen: assert property (disable iff (!rstn)
    !pins.hold_n [*8] |=> $stable(so)) else $error("so moved while paused");
  a_oe_drop_cause: assert property (disable iff (!rstn)
    $fell(so_oe) |-> sel_q < 4'h9) else $error("so released mid frame");
  a_oe_rise_sel: assert property (disable iff (!rstn)
    $rose(so_oe) |-> !pins.cs_n && !$past(pins.cs_n, 8))
    else $error("so driven without selection");
  c_read: cover property (disable iff (!rstn) $rose(so_oe));
  c_pause: cover property (disable iff (!rstn) so_oe && !pins.hold_n);
  c_busy: cover property (disable iff (!rstn) pins.cs_n && !standby);
endmodule
bind sxe_eeprom sxe_eeprom_sva u_sva (
  .clk_sys(clk_sys),
  .rstn   (rstn),
  .pins   (pins),
  .so     (so),
  .so_oe  (so_oe),
  .standby(standby)
);
`default_nettype wire

// [sxe_host.sv]
/* host serial master model, mode 0, msb first.
   assumes: tasks called from the bench at clk_sys falling edges. */
`timescale 1ns/1ps
`default_nettype none
module sxe_host (
  input  wire logic              clk_sys,
  input  wire logic              so,
  input  wire logic              so_oe,
  output var sxe_pkg::sxe_pins_t p
);
  import sxe_pkg::*;
  logic so_w;
  // released line shows the inverse, so a stale bit never passes
  assign so_w = so_oe ? so : ~so;
  initial p = 5'h03; // powers up already selected, no edge yet
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic sel();
    p.cs_n = 1'b1;
    tick(8);
    p.cs_n = 1'b0;
    tick(8);
  endtask
  task automatic desel();
    tick(4);
    p.cs_n = 1'b1;
    tick(8);
  endtask
  // n bits msb first; pause with dummy clocks before bit pb
  task automatic xfer(input logic [7:0] tx, input int n, input int pb,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n && i >= 0; i--) begin
      p.si = tx[i];
      tick(4);
      if (i == pb) begin
        p.hold_n = 1'b0;
        // pause must settle first, or the first dummy clock is taken
        tick(8);
        repeat (2) begin
          p.sck = 1'b1;
          p.si = ~p.si;
          tick(4);
          p.sck = 1'b0;
          tick(4);
        end
        p.si = tx[i];
        p.hold_n = 1'b1;
        tick(8);
      end
      p.sck = 1'b1;
      tick(4);
      rx = {rx[6:0], so_w};
      p.sck = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// [tb_sxe_eeprom.sv]
/* bench for sxe_eeprom driven through the host model.
   assumes: package, host model and checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_sxe_eeprom;
  import sxe_pkg::*;
  localparam int WR = 200;
  logic       clk_sys = 1'b0;
  logic       rstn = 1'b0;
  logic       so;
  logic       so_oe;
  logic       standby;
  sxe_pins_t  pins;
  int         error_cnt = 0;
  int         total_checks = 0;
  int         cyc = 0;
  logic [7:0] v;
  logic [7:0] w;
  always #10 clk_sys = ~clk_sys;
  sxe_host host (.clk_sys(clk_sys), .so(so), .so_oe(so_oe), .p(pins));
  sxe_eeprom #(.WR_CYCLES(WR)) dut (.clk_sys(clk_sys), .rstn(rstn),
    .pins(pins), .so(so), .so_oe(so_oe), .standby(standby));
  task automatic chk(input string s, input logic [7:0] e,
                     input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic cmd(input logic [7:0] op);
    host.sel();
    host.xfer(op, 8, -1, w);
    host.desel();
  endtask
  task automatic status_read_cmd(input int pb);
    host.sel();
    host.xfer(8'h05, 8, pb, w);
    host.xfer(8'h00, 8, pb - 8, v);
    host.desel();
  endtask
  // latch, then op and n bits of d; n off a byte boundary cuts the frame
  task automatic wr(input logic [7:0] op, input logic [31:0] d,
                    input int n);
    cmd(8'h06);
    host.sel();
    host.xfer(op, 8, -1, w);
    for (int i = 0; i < n; i += 8)
      host.xfer(d[31-i -: 8], n - i, -1, w);
    host.desel();
  endtask
  task automatic rd(input logic [15:0] a);
    host.sel();
    host.xfer(8'h03, 8, -1, w);
    host.xfer(a[15:8], 8, -1, w);
    host.xfer(a[7:0], 8, -1, w);
    host.xfer(8'h00, 8, -1, v);
    host.xfer(8'h00, 8, -1, w);
    host.desel();
  endtask
  task automatic t_power();
    host.tick(1);
    chk("standby", 8'h01, {7'h00, standby});
    host.xfer(8'h06, 8, -1, w);
    host.desel();
    status_read_cmd(-1);
    chk("latch without select edge", 8'h00, v);
  endtask
  task automatic t_latch();
    cmd(8'h06);
    status_read_cmd(3);
    chk("latch set, paused opcode", 8'h02, v);
    status_read_cmd(12);
    chk("status, paused output", 8'h02, v);
    cmd(8'h04);
    status_read_cmd(-1);
    chk("latch cleared", 8'h00, v);
  endtask
  task automatic t_status();
    wr(8'h01, 32'hff000000, 8);
    chk("standby while busy", 8'h00, {7'h00, standby});
    status_read_cmd(-1);
    chk("status while busy", 8'hff, v);
    host.tick(WR + 20);
    status_read_cmd(-1);
    chk("status written", 8'h8c, v);
    host.p.wp_n = 1'b0;
    wr(8'h01, 32'h0, 8);
    status_read_cmd(-1);
    chk("guarded status write", 8'h8e, v);
    host.p.wp_n = 1'b1;
    host.sel();
    host.xfer(8'h01, 8, -1, w);
    host.p.wp_n = 1'b0;
    host.xfer(8'h00, 8, -1, w);
    host.desel();
    host.p.wp_n = 1'b1;
    status_read_cmd(-1);
    chk("status write abandoned", 8'h8e, v);
    wr(8'h01, 32'h0, 8);
    host.tick(WR + 20);
    host.p.wp_n = 1'b0;
    wr(8'h01, 32'h04000000, 8);
    host.tick(WR + 20);
    host.p.wp_n = 1'b1;
    status_read_cmd(-1);
    chk("pin ignored, guard bit clear", 8'h04, v);
  endtask
  task automatic t_misc();
    host.sel();
    host.xfer(8'hff, 8, -1, w);
    host.xfer(8'h00, 8, -1, w);
    chk("drive after unknown opcode", 8'h00, {7'h00, so_oe});
    host.desel();
    wr(8'h02, 32'h00005500, 28);
    status_read_cmd(-1);
    chk("write cut mid byte", 8'h06, v);
  endtask
  task automatic t_array();
    logic [12:0] a [3];
    logic [7:0]  ea [3];
    logic [7:0]  eb [3];
    logic [7:0]  d;
    a = '{13'h001f, 13'h101f, 13'h1fff};
    for (int c = 0; c < 4; c++) begin
      wr(8'h01, {4'h0, c[1:0], 26'h0}, 8);
      host.tick(WR + 20);
      for (int i = 0; i < 3; i++) begin
        d = {c[3:0], i[3:0]};
        wr(8'h02, {3'h7, a[i], d, ~d}, 32);
        status_read_cmd(-1);
        chk("busy after array write", 8'hff, v);
        host.tick(WR + 20);
        if (c == 0 || (c == 1 && a[i] < 13'h1800) ||
            (c == 2 && a[i] < 13'h1000)) begin
          ea[i] = d;
          eb[i] = ~d;
        end
      end
      for (int i = 0; i < 3; i++) begin
        rd({3'h7, a[i]});
        chk("array byte", ea[i], v);
        rd({3'h0, a[i] & 13'h1fe0});
        chk("page wrapped byte", eb[i], v);
      end
      rd(16'hffff);
      chk("read wrap", eb[0], w);
    end
  endtask
  initial begin
    repeat (8) @(negedge clk_sys);
    rstn = 1'b1;
    t_power();
    t_latch();
    t_status();
    t_misc();
    t_array();
    end_of_test();
  end
endmodule
`default_nettype wire
